// ---- vq_notify_pkg.sv ----
/*
  Package for the queue doorbell and interrupt block: register offsets,
  field positions, reset values and encodings.
  Assumes a plain 32-bit register port with byte-style offsets.
*/
package vq_notify_pkg;
  localparam int unsigned NUM_QUEUES = 4;
  localparam int unsigned QSEL_W = 2;
  localparam logic [31:0] PAGE_SIZE = 32'h0000_1000;
  localparam int unsigned PAGE_SHIFT = 12;
  localparam logic [15:0] QUEUE_SIZE_FIXED = 16'h0100;
  localparam logic [15:0] NO_VECTOR = 16'hffff;
  localparam logic [10:0] MAX_TABLE_ENTRY = 11'h7ff;

  // register offsets
  localparam logic [7:0] OFS_QUEUE_PFN = 8'h08;
  localparam logic [7:0] OFS_QUEUE_SIZE = 8'h0c;
  localparam logic [7:0] OFS_QUEUE_SEL = 8'h0e;
  localparam logic [7:0] OFS_QUEUE_NOTIFY = 8'h10;
  localparam logic [7:0] OFS_CAUSE = 8'h13;
  localparam logic [7:0] OFS_CFG_VECTOR = 8'h14;
  localparam logic [7:0] OFS_QUEUE_VECTOR = 8'h16;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

  // control fields
  localparam int unsigned CTL_MSIX_EN = 0;
  localparam int unsigned CTL_NOTIF_DATA = 1;
  localparam int unsigned CTL_CFG_DATA = 2;

  // cause register bits
  localparam int unsigned CAUSE_USED = 0;
  localparam int unsigned CAUSE_CFG = 1;

  // doorbell word fields
  localparam int unsigned DB_ID_LSB = 0;
  localparam int unsigned DB_ID_W = 16;
  localparam int unsigned DB_OFF_LSB = 16;
  localparam int unsigned DB_OFF_W = 15;
  localparam int unsigned DB_WRAP_BIT = 31;

  // status events
  localparam int unsigned EV_DOORBELL = 0;
  localparam int unsigned EV_BAD_ID = 1;
  localparam int unsigned EV_MSG_DROP = 2;
  localparam int unsigned EV_W = 3;

  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ---- vq_doorbell_decode.sv ----
/*
  Doorbell decoder: splits a notify write into queue id, offset and wrap.
  Assumes the write is qualified by the caller; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module vq_doorbell_decode
  import vq_notify_pkg::*;
(
  // doorbell input
  input wire logic [31:0] data_i,
  input wire logic notif_data_i,
  // decoded fields
  output logic [15:0] queue_id_o,
  output logic [14:0] next_off_o,
  output logic next_wrap_o
);
  always_comb begin
    queue_id_o = data_i[DB_ID_LSB +: DB_ID_W];
    // short doorbells carry only the 16-bit value
    if (notif_data_i) begin
      next_off_o = data_i[DB_OFF_LSB +: DB_OFF_W];
      next_wrap_o = data_i[DB_WRAP_BIT];
    end else begin
      next_off_o = 15'h0000;
      next_wrap_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- vq_notify_irq.sv ----
/*
  Queue doorbell decode and interrupt delivery: cause register with line
  interrupt, or per-event message vectors. Also the legacy page number.
  Assumes one clock, synchronous reset and a one-cycle register port.
*/
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: queue base is the written page number times 4096.
// R2: queue size is fixed; writes to it change nothing.
// R3: without notify data, a 16-bit write is a doorbell.
// R4: with notify data, a 32-bit little-endian write is a doorbell.
// R5: doorbell word: id bits 15:0, offset 15 bits, wrap top bit.
// R6: driver puts queue index or config value in the id field.
// R7: used event without messages sets cause bit 0 and line irq.
// R8: with messages, used event goes to the queue vector unless unmapped.
// R9: config change without messages sets cause bit 1 and line irq.
// R10: with messages, config change goes to config vector unless unmapped.
// R11: one delivery may report queue and config events together.
// R12: driver handles a combined queue and config interrupt.
// R13: reading the cause register returns its bits and clears them.
// R14: line-mode handler reads cause, scans queues or rereads config.
// R15: message handler scans vector queues, rereads config on match.
// R16: vector 0xffff means unmapped and disables that event.
// R17: reset leaves every event unmapped.
// R18: with messages enabled, the cause register is not used.
// R19: line irq drops when cleared, unless an event sets in that cycle.
module vq_notify_irq
  import vq_notify_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wide_i,
  output logic [31:0] reg_rdata_o,
  // device events
  input wire logic [NUM_QUEUES-1:0] used_event_i,
  input wire logic cfg_change_i,
  // doorbell out
  output logic doorbell_o,
  output logic [15:0] doorbell_queue_o,
  output logic [14:0] doorbell_off_o,
  output logic doorbell_wrap_o,
  // queue base
  output logic [43:0] queue_base_o,
  // message request
  output logic msg_req_o,
  output logic [10:0] msg_vector_o,
  // line interrupts
  output logic line_irq_o,
  output logic irq_o
);
  typedef enum {MSG_IDLE, MSG_SEND} msg_state_t;

  logic [2:0] control_r;
  logic [QSEL_W-1:0] queue_sel_r;
  logic [31:0] queue_pfn_r [NUM_QUEUES];
  logic [15:0] queue_vec_r [NUM_QUEUES];
  logic [15:0] cfg_vec_r;
  logic [1:0] cause_r;
  logic [1:0] cause_nxt;
  logic [EV_W-1:0] irq_status_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [EV_W-1:0] ev_set;
  logic [NUM_QUEUES-1:0] q_pend_r;
  logic cfg_pend_r;
  logic [QSEL_W-1:0] send_q;
  logic send_found;
  // doorbell decode results
  logic [15:0] dec_id;
  logic [14:0] dec_off;
  logic dec_wrap;
  logic db_wr;
  logic db_ok;
  logic cause_rd;
  logic msix_en;
  logic [15:0] vec_wdata;
  msg_state_t msg_state_r;

  assign msix_en = control_r[CTL_MSIX_EN];
  assign cause_rd = reg_rd_i && (reg_addr_i == OFS_CAUSE);
  // a vector beyond the table reads back as unmapped
  assign vec_wdata = (reg_wdata_i[15:0] <= 16'(MAX_TABLE_ENTRY)) ?
                     reg_wdata_i[15:0] : NO_VECTOR;

  // R3 R4 width check
  assign db_wr = reg_wr_i && (reg_addr_i == OFS_QUEUE_NOTIFY) &&
                 (reg_wide_i == control_r[CTL_NOTIF_DATA]);

  vq_doorbell_decode vq_doorbell_decode_i (
    .data_i(reg_wdata_i),
    .notif_data_i(control_r[CTL_NOTIF_DATA]),
    .queue_id_o(dec_id),
    .next_off_o(dec_off),
    .next_wrap_o(dec_wrap)
  );

  // config-data ids are opaque; only plain indices are range checked
  assign db_ok = control_r[CTL_CFG_DATA] || (dec_id < 16'(NUM_QUEUES));

  // feature bits and queue select
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      control_r <= 3'h0;
      queue_sel_r <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_CONTROL) begin
        control_r <= reg_wdata_i[2:0];
      end else if (reg_addr_i == OFS_QUEUE_SEL) begin
        queue_sel_r <= reg_wdata_i[QSEL_W-1:0];
      end
    end
  end

  // per-queue page number and vector storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_QUEUES; gi++) begin : g_queue
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          queue_pfn_r[gi] <= 32'h0000_0000;
          // R17 reset unmapped
          queue_vec_r[gi] <= NO_VECTOR;
        end else if (reg_wr_i && queue_sel_r == QSEL_W'(gi)) begin
          if (reg_addr_i == OFS_QUEUE_PFN) begin
            queue_pfn_r[gi] <= reg_wdata_i;
          end else if (reg_addr_i == OFS_QUEUE_VECTOR) begin
            queue_vec_r[gi] <= vec_wdata;
          end
        end
      end
    end
  endgenerate

  // config vector, range-checked like the queue vectors
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      // R17 config unmapped
      cfg_vec_r <= NO_VECTOR;
    end else if (reg_wr_i && reg_addr_i == OFS_CFG_VECTOR) begin
      cfg_vec_r <= vec_wdata;
    end
  end

  // R1 page to base
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      queue_base_o <= 44'h000_0000_0000;
    end else begin
      queue_base_o <= {queue_pfn_r[queue_sel_r], {PAGE_SHIFT{1'b0}}};
    end
  end

  // R5 doorbell fields
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      doorbell_o <= 1'b0;
      doorbell_queue_o <= 16'h0000;
      doorbell_off_o <= 15'h0000;
      doorbell_wrap_o <= 1'b0;
    end else begin
      doorbell_o <= db_wr && db_ok;
      if (db_wr && db_ok) begin
        doorbell_queue_o <= dec_id;
        doorbell_off_o <= dec_off;
        doorbell_wrap_o <= dec_wrap;
      end
    end
  end

  // R13 clear on read, set wins
  always_comb begin
    cause_nxt = cause_rd ? 2'b00 : cause_r;
    // R18 no cause in message mode
    if (!msix_en) begin
      // R7 used sets bit 0
      if (|used_event_i) begin
        cause_nxt[CAUSE_USED] = 1'b1;
      end
      // R9 config sets bit 1
      if (cfg_change_i) begin
        cause_nxt[CAUSE_CFG] = 1'b1;
      end
    end
  end

  // cause register, cleared by its own read
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cause_r <= 2'b00;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // R19 line follows cause
  // from the next value, so a read and a new event together keep it up
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      line_irq_o <= 1'b0;
    end else begin
      // R11 one line for both causes
      line_irq_o <= |cause_nxt;
    end
  end

  // pending message events, lowest-index-first scan by queue index
  always_comb begin
    send_q = '0;
    send_found = 1'b0;
    for (int i = NUM_QUEUES - 1; i >= 0; i--) begin
      if (q_pend_r[i]) begin
        send_q = QSEL_W'(i);
        send_found = 1'b1;
      end
    end
  end

  // one message every two cycles keeps each request a lone pulse
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q_pend_r <= '0;
      cfg_pend_r <= 1'b0;
      msg_state_r <= MSG_IDLE;
      msg_req_o <= 1'b0;
      msg_vector_o <= 11'h000;
    end else begin
      msg_req_o <= 1'b0;
      case (msg_state_r)
        MSG_IDLE: begin
          if (cfg_pend_r) begin
            msg_req_o <= 1'b1;
            msg_vector_o <= cfg_vec_r[10:0];
            cfg_pend_r <= 1'b0;
            msg_state_r <= MSG_SEND;
          end else if (send_found) begin
            msg_req_o <= 1'b1;
            msg_vector_o <= queue_vec_r[send_q][10:0];
            q_pend_r[send_q] <= 1'b0;
            msg_state_r <= MSG_SEND;
          end
        end
        MSG_SEND: begin
          msg_state_r <= MSG_IDLE;
        end
        default: begin
          msg_state_r <= MSG_IDLE;
        end
      endcase
      // events coalesce per queue while a message waits
      // R8 R16 queue vector gate; new events win over the clear above
      for (int i = 0; i < NUM_QUEUES; i++) begin
        if (msix_en && used_event_i[i] && queue_vec_r[i] != NO_VECTOR) begin
          q_pend_r[i] <= 1'b1;
        end
      end
      // R10 R16 config vector gate
      if (msix_en && cfg_change_i && cfg_vec_r != NO_VECTOR) begin
        cfg_pend_r <= 1'b1;
      end
    end
  end

  // status events for the local interrupt
  always_comb begin
    ev_set = '0;
    ev_set[EV_DOORBELL] = db_wr && db_ok;
    ev_set[EV_BAD_ID] = (db_wr && !db_ok) ||
                        (reg_wr_i && reg_addr_i == OFS_QUEUE_NOTIFY && !db_wr);
    ev_set[EV_MSG_DROP] = msix_en && cfg_change_i && (cfg_vec_r == NO_VECTOR);
    // a mapped queue must not hide an unmapped one firing in the same cycle
    for (int i = 0; i < NUM_QUEUES; i++) begin
      if (msix_en && used_event_i[i] && queue_vec_r[i] == NO_VECTOR) begin
        ev_set[EV_MSG_DROP] = 1'b1;
      end
    end
  end

  // local status and mask
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_status_r <= '0;
      irq_mask_r <= '0;
    end else begin
      // write one to clear; a same-cycle event keeps its bit
      if (reg_wr_i && reg_addr_i == OFS_IRQ_STATUS) begin
        irq_status_r <= (irq_status_r & ~reg_wdata_i[EV_W-1:0]) | ev_set;
      end else begin
        irq_status_r <= irq_status_r | ev_set;
      end
      if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
        irq_mask_r <= reg_wdata_i[EV_W-1:0];
      end
    end
  end

  // mask applied after the status flop, one cycle of latency
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == OFS_QUEUE_PFN) begin
        reg_rdata_o <= queue_pfn_r[queue_sel_r];
      end else if (reg_addr_i == OFS_QUEUE_SIZE) begin
        // R2 fixed size
        reg_rdata_o <= {16'h0000, QUEUE_SIZE_FIXED};
      end else if (reg_addr_i == OFS_QUEUE_SEL) begin
        reg_rdata_o <= {{(32-QSEL_W){1'b0}}, queue_sel_r};
      end else if (reg_addr_i == OFS_CAUSE) begin
        reg_rdata_o <= {30'h0, cause_r};
      end else if (reg_addr_i == OFS_CFG_VECTOR) begin
        reg_rdata_o <= {16'h0000, cfg_vec_r};
      end else if (reg_addr_i == OFS_QUEUE_VECTOR) begin
        reg_rdata_o <= {16'h0000, queue_vec_r[queue_sel_r]};
      end else if (reg_addr_i == OFS_CONTROL) begin
        reg_rdata_o <= {29'h0, control_r};
      end else if (reg_addr_i == OFS_IRQ_STATUS) begin
        reg_rdata_o <= {{(32-EV_W){1'b0}}, irq_status_r};
      end else if (reg_addr_i == OFS_IRQ_MASK) begin
        reg_rdata_o <= {{(32-EV_W){1'b0}}, irq_mask_r};
      end else begin
        reg_rdata_o <= RD_UNMAPPED;
      end
    end else begin
      // idle data is zero so a stale word never looks like an answer
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ---- vq_notify_checker.sv ----
/* Port checker for vq_notify_irq, bound below.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module vq_notify_checker
  import vq_notify_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wide_i,
  input wire logic [31:0] reg_rdata_o,
  // events and results
  input wire logic [NUM_QUEUES-1:0] used_event_i,
  input wire logic cfg_change_i,
  input wire logic doorbell_o,
  input wire logic [15:0] doorbell_queue_o,
  input wire logic [14:0] doorbell_off_o,
  input wire logic doorbell_wrap_o,
  input wire logic [43:0] queue_base_o,
  input wire logic line_irq_o
);
  // shadow of control, the feature bits are not ports
  logic [2:0] ctl_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) ctl_r <= 3'h0;
    else if (reg_wr_i && reg_addr_i == OFS_CONTROL) ctl_r <= reg_wdata_i[2:0];
  end
  sequence ntf_s;
    reg_wr_i && reg_addr_i == OFS_QUEUE_NOTIFY;
  endsequence
  sequence ok_s;
    ntf_s ##0 reg_wide_i == ctl_r[CTL_NOTIF_DATA] ##0
      (ctl_r[CTL_CFG_DATA] || reg_wdata_i[15:0] < NUM_QUEUES);
  endsequence
  db_accept_a: assert property (
    ok_s |=> doorbell_o && doorbell_queue_o == $past(reg_wdata_i[15:0]))
    else $error("accepted notify gave no doorbell");
  db_refuse_a: assert property (
    ntf_s ##0 reg_wide_i != ctl_r[CTL_NOTIF_DATA] |=> !doorbell_o)
    else $error("wrong width notify accepted");
  db_wide_a: assert property (
    ok_s ##0 reg_wide_i |=> doorbell_off_o == $past(reg_wdata_i[30:16])
      && doorbell_wrap_o == $past(reg_wdata_i[31]))
    else $error("doorbell offset or wrap wrong");
  used_line_a: assert property (
    used_event_i != '0 && !ctl_r[CTL_MSIX_EN] |=> line_irq_o)
    else $error("used event raised no line irq");
  cfg_line_a: assert property (
    cfg_change_i && !ctl_r[CTL_MSIX_EN] |=> line_irq_o)
    else $error("config change raised no line irq");
  cause_clear_a: assert property (
    reg_rd_i && reg_addr_i == OFS_CAUSE && used_event_i == '0 && !cfg_change_i
      |=> !line_irq_o)
    else $error("line irq stayed after cause read");
  size_fixed_a: assert property (
    reg_rd_i && reg_addr_i == OFS_QUEUE_SIZE |=> reg_rdata_o[15:0] == QUEUE_SIZE_FIXED)
    else $error("queue size not fixed");
  page_base_a: assert property (
    reg_wr_i && reg_addr_i == OFS_QUEUE_PFN |-> ##2
      queue_base_o == {$past(reg_wdata_i, 2), 12'h000})
    else $error("queue base not page times 4096");
endmodule
bind vq_notify_irq vq_notify_checker vq_notify_checker_i (.clk_sys_i, .reset_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_wide_i, .reg_rdata_o, .used_event_i,
  .cfg_change_i, .doorbell_o, .doorbell_queue_o, .doorbell_off_o, .doorbell_wrap_o,
  .queue_base_o, .line_irq_o);
`default_nettype wire

// ---- host_driver_model.sv ----
/* Host driver model: register port master and message sorter.
   Assumes read data one cycle after the strobe, no wait states. */
`timescale 1ns/10ps
`default_nettype none
module host_driver_model
  import vq_notify_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // register port
  output var logic [7:0] addr_o,
  output var logic [31:0] wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic wide_o,
  input wire logic [31:0] rdata_i,
  // messages
  input wire logic msg_req_i,
  input wire logic [10:0] msg_vector_i
);
  logic [15:0] cfg_vec_r = NO_VECTOR;
  int cfg_hits = 0;
  int queue_hits = 0;
  initial {addr_o, wdata_o, wr_o, rd_o, wide_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wide_o <= w;
    wr_o <= 1'b1;
    if (a == OFS_CFG_VECTOR) cfg_vec_r <= d[15:0];
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    // idle bus never echoes the last value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = rdata_i;
  endtask
  task automatic db(input logic [15:0] id, input logic [15:0] hi, input logic w);
    wr(OFS_QUEUE_NOTIFY, {hi, id}, w);
  endtask
  task automatic service(output logic [31:0] c);
    rd(OFS_CAUSE, c);
  endtask
  always @(posedge clk_sys_i) begin
    if (msg_req_i && msg_vector_i == cfg_vec_r[10:0]) cfg_hits++;
    else if (msg_req_i) queue_hits++;
  end
endmodule
`default_nettype wire

// ---- vq_notify_irq_tb.sv ----
/* Self-checking bench for vq_notify_irq beside a host driver model.
   Assumes a 40 MHz clock and the offsets of the package. */
`timescale 1ns/10ps
`default_nettype none
module vq_notify_irq_tb
  import vq_notify_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr, rd, wide, db, db_wrap, mreq, line, irq;
  logic cfg_ev = 1'b0;
  logic [NUM_QUEUES-1:0] used_ev = '0;
  logic [7:0] addr;
  logic [10:0] mvec, cv;
  logic [14:0] db_off;
  logic [15:0] db_q, id, hi;
  logic [15:0] vec_m[NUM_QUEUES];
  logic [31:0] wdata, rdata, r;
  logic [43:0] qbase;
  logic [10:0] got_q[$], exp_q[$];
  int fail_count = 0;
  int total_checks = 0;
  int q;
  int exp_cfg;
  vq_notify_irq vq_notify_irq_i (.clk_sys_i, .reset_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wide_i(wide), .reg_rdata_o(rdata),
    .used_event_i(used_ev), .cfg_change_i(cfg_ev), .doorbell_o(db), .doorbell_queue_o(db_q),
    .doorbell_off_o(db_off), .doorbell_wrap_o(db_wrap), .queue_base_o(qbase),
    .msg_req_o(mreq), .msg_vector_o(mvec), .line_irq_o(line), .irq_o(irq));
  host_driver_model h (.clk_sys_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .wide_o(wide), .rdata_i(rdata), .msg_req_i(mreq), .msg_vector_i(mvec));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (mreq === 1'b1) got_q.push_back(mvec);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ev(input logic [NUM_QUEUES-1:0] u, input logic c);
    @(posedge clk_sys_i);
    used_ev <= u;
    cfg_ev <= c;
    @(posedge clk_sys_i);
    used_ev <= '0;
    cfg_ev <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // span far above the roughly 4.4 us the tests take
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(64));
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    h.rd(OFS_CFG_VECTOR, r);
    chk(r[15:0], NO_VECTOR);
    h.rd(8'h3c, r);
    chk(r, RD_UNMAPPED);
    for (q = 0; q < NUM_QUEUES; q++) begin
      h.wr(OFS_QUEUE_SEL, q, 1'b0);
      h.rd(OFS_QUEUE_VECTOR, r);
      chk(r[15:0], NO_VECTOR);
      h.wr(OFS_QUEUE_SIZE, $urandom, 1'b0);
      h.rd(OFS_QUEUE_SIZE, r);
      chk(r[15:0], QUEUE_SIZE_FIXED);
      r = $urandom;
      h.wr(OFS_QUEUE_PFN, r, 1'b0);
      @(posedge clk_sys_i);
      #1 chk(qbase, {r, 12'h000});
      // last queue gets an out-of-table entry
      vec_m[q] = (q == 3) ? 16'hf800 : 16'($urandom & 32'h7ff);
      h.wr(OFS_QUEUE_VECTOR, {16'h0, vec_m[q]}, 1'b0);
      if (q == 3) vec_m[q] = NO_VECTOR;
      h.rd(OFS_QUEUE_VECTOR, r);
      chk(r[15:0], vec_m[q]);
    end
    for (q = 0; q < 4; q++) begin
      h.wr(OFS_CONTROL, 32'(q << 1), 1'b0);
      hi = 16'($urandom);
      id = q[1] ? 16'($urandom) : 16'($urandom % NUM_QUEUES);
      h.db(id, hi, q[0]);
      #1 chk(db, 1'b1);
      chk({db_q, db_off, db_wrap}, q[0] ? {id, hi[14:0], hi[15]} : {id, 16'h0});
      h.db(id, hi, !q[0]);
      #1 chk(db, 1'b0);
    end
    h.rd(OFS_IRQ_STATUS, r);
    chk(r[2:0], 3'h3);
    h.wr(OFS_IRQ_MASK, 32'h1, 1'b0);
    @(posedge clk_sys_i);
    #1 chk(irq, 1'b1);
    h.wr(OFS_IRQ_STATUS, 32'h7, 1'b0);
    @(posedge clk_sys_i);
    #1 chk(irq, 1'b0);
    h.wr(OFS_CONTROL, 32'h0, 1'b0);
    for (q = 1; q < 4; q++) begin
      ev(q[0] ? 4'(1 << ($urandom % 4)) : 4'h0, q[1]);
      chk(line, 1'b1);
      h.service(r);
      chk(r[1:0], q[1:0]);
      chk(line, 1'b0);
      h.service(r);
      chk(r[1:0], 2'h0);
    end
    cv = 11'($urandom);
    h.wr(OFS_CFG_VECTOR, {21'h0, cv}, 1'b0);
    h.wr(OFS_CONTROL, 32'h1, 1'b0);
    got_q.delete();
    ev(4'hf, 1'b1);
    repeat (12) @(posedge clk_sys_i);
    exp_q = {cv};
    for (q = 0; q < 4; q++) if (vec_m[q] != NO_VECTOR) exp_q.push_back(vec_m[q][10:0]);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    exp_cfg = 0;
    foreach (exp_q[i]) if (exp_q[i] == cv) exp_cfg++;
    chk(h.cfg_hits, exp_cfg);
    chk(h.queue_hits, exp_q.size() - exp_cfg);
    chk(line, 1'b0);
    h.service(r);
    chk(r[1:0], 2'h0);
    h.rd(OFS_IRQ_STATUS, r);
    chk(r[2], 1'b1);
    h.wr(OFS_CFG_VECTOR, {16'h0, NO_VECTOR}, 1'b0);
    got_q.delete();
    ev(4'h0, 1'b1);
    repeat (6) @(posedge clk_sys_i);
    chk(got_q.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
